// ---- verilog/cpp_position_input.sv ----
// Command pulse decoder, electronic gear, smoothing and deviation counter
// Function
// - Form 0 counts low pulses on forward input up, on reverse input down.
// - Form 2 decodes low-active A/B quadrature, counting every edge, four per cycle.
// - Forms 3, 4, 5 are the high-active versions of forms 0, 1, 2.
// - Deviation counter accumulates scaled command minus encoder feedback.
// - Steady droop equals command frequency over loop gain, default gain 25.
// - Nonzero smoothing time filters the scaled command rate.
// - Smoothing ramps abrupt rate changes; zero means no smoothing.
// - Scale each command count by numerator over denominator, both 0..32767, default 1.
// - In-position flag set while droop magnitude is below the in-position width.
// - Rising edge of the clear input zeroes the deviation counter.
//
// Local design decisions: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "cpp_params.svh"
module cpp_position_input
    import cpp_pkg::*;
#(
    parameter int MS_CYCLES = `CPP_MS_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire cpp_wb_req_t wb_req_i,
    output var cpp_wb_rsp_t wb_rsp_o,
    input wire logic fwd_pulse_input_i,
    input wire logic rev_pulse_input_i,
    input wire logic counter_clear_input_i,
    input wire logic enc_a_i,
    input wire logic enc_b_i,
    output var logic inposition_flag_o,
    output var logic irq_o,
    output var logic signed [40:0] speed_cmd_o
);
    localparam int MSW = $clog2(MS_CYCLES + 1);
    localparam int SHN = 16;

    // Pin synchronisers: bit 0 fwd, 1 rev, 2 clear, 3 enc A, 4 enc B
    logic [4:0] s1_q;
    logic [4:0] s2_q;
    logic [4:0] s3_q;
    logic [1:0] prime_q;
    logic [2:0] form_q;
    logic [14:0] gear_num_q;
    logic [14:0] gear_den_q;
    logic [7:0] gain_q;
    logic [15:0] smooth_q;
    logic [14:0] inpos_q;
    logic [2:0] status_q;
    logic [2:0] int_en_q;
    logic signed [35:0] frac_q;
    logic signed [31:0] back_q;
    logic signed [31:0] droop_q;
    logic [MSW-1:0] ms_cnt_q;
    cpp_div_state_t div_st_q;
    logic [31:0] dvd_q;
    logic [32:0] rem_q;
    logic [5:0] div_cnt_q;
    logic div_neg_q;
    logic div_done_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_q <= 5'h00;
            s2_q <= 5'h00;
            s3_q <= 5'h00;
            prime_q <= 2'h0;
        end else begin
            s1_q <= {enc_b_i, enc_a_i, counter_clear_input_i,
                     rev_pulse_input_i, fwd_pulse_input_i};
            s2_q <= s1_q;
            s3_q <= s2_q;
            // Edges seen before the history is filled are reset artefacts
            if (prime_q != 2'h3) begin
                prime_q <= prime_q + 2'h1;
            end
        end
    end

    wire primed = (prime_q == 2'h3);

    // Command decode
    wire pos_logic = (form_q >= CPP_FORM_SEP_POS);
    wire [2:0] form_sub = pos_logic ? 3'(form_q - CPP_FORM_SEP_POS) : form_q;
    wire a_now = pos_logic ? s2_q[0] : ~s2_q[0];
    wire a_prv = pos_logic ? s3_q[0] : ~s3_q[0];
    wire b_now = pos_logic ? s2_q[1] : ~s2_q[1];
    wire b_prv = pos_logic ? s3_q[1] : ~s3_q[1];
    wire a_edge = primed & a_now & ~a_prv;
    wire b_edge = primed & b_now & ~b_prv;
    wire [2:0] cq = cpp_quad(a_prv, b_prv, a_now, b_now);
    wire is_sep = (form_sub == CPP_FORM_SEP_NEG);
    wire is_step = (form_sub == CPP_FORM_STEP_NEG);
    wire is_quad = (form_sub == CPP_FORM_QUAD_NEG);
    wire sep_up = is_sep & a_edge & ~b_edge;
    wire sep_dn = is_sep & b_edge & ~a_edge;
    wire step_up = is_step & a_edge & b_now;
    wire step_dn = is_step & a_edge & ~b_now;
    wire quad_up = is_quad & primed & cq[2] & cq[1];
    wire quad_dn = is_quad & primed & cq[2] & ~cq[1];
    wire quad_err = is_quad & primed & cq[0];
    wire cmd_up = sep_up | step_up | quad_up;
    wire cmd_dn = sep_dn | step_dn | quad_dn;

    // Encoder feedback, always positive logic, A leading B forward
    wire [2:0] fq = cpp_quad(s3_q[3], s3_q[4], s2_q[3], s2_q[4]);
    wire fb_up = primed & fq[2] & fq[1];
    wire fb_dn = primed & fq[2] & ~fq[1];
    wire clr_rise = primed & s2_q[2] & ~s3_q[2];

    // Electronic gear: remainder keeps fractions so no count is lost
    wire signed [35:0] num_s = 36'(gear_num_q);
    wire signed [35:0] frac_in = cmd_up ? frac_q + num_s :
                                 cmd_dn ? frac_q - num_s : frac_q;
    wire frac_neg = frac_in[35];
    wire [35:0] frac_mag = frac_neg ? 36'(-frac_in) : 36'(frac_in);
    wire den_zero = (gear_den_q == 15'h0000);
    wire [35:0] den_sh [SHN];
    wire [SHN-1:0] den_ge;

    // Large ratios emit up to a power-of-two block of counts per cycle
    genvar gk;
    generate
        for (gk = 0; gk < SHN; gk++) begin : g_shift
            assign den_sh[gk] = 36'(gear_den_q) << gk;
            assign den_ge[gk] = (frac_mag >= den_sh[gk]);
        end
    endgenerate

    logic [3:0] shk;
    always_comb begin
        shk = 4'h0;
        for (int k = 0; k < SHN; k++) begin
            if (den_ge[k]) begin
                shk = 4'(k);
            end
        end
    end

    wire emit = ~den_zero & den_ge[0];
    wire [17:0] emit_mag = emit ? 18'(18'h0_0001 << shk) : 18'h0_0000;
    wire signed [31:0] sd = frac_neg ? -32'(emit_mag) : 32'(emit_mag);
    wire [35:0] emit_den = emit ? den_sh[shk] : 36'h0_0000_0000;
    wire signed [35:0] frac_d = den_zero ? 36'sh0_0000_0000 :
                                frac_neg ? frac_in + $signed(emit_den) :
                                frac_in - $signed(emit_den);

    // Smoothing: each ms, release backlog divided by the time constant
    wire smooth_off = (smooth_q == 16'h0000);
    wire ms_tick = (ms_cnt_q == MSW'(MS_CYCLES - 1));
    wire [31:0] back_mag = back_q[31] ? 32'(-back_q) : 32'(back_q);
    wire div_start = ms_tick & ~smooth_off & (div_st_q == CPP_DIV_IDLE)
                     & (back_q != 32'sh0000_0000);
    wire [32:0] rem_sh = {rem_q[31:0], dvd_q[31]};
    wire rem_ge = (rem_sh >= 33'(smooth_q));
    // Never release zero while a backlog is left, or it would stall forever
    wire [31:0] q_rel = (dvd_q == 32'h0000_0000) ? 32'h0000_0001 : dvd_q;
    wire signed [31:0] rel = smooth_off ? back_q + sd :
                             div_done_q ? (div_neg_q ? -$signed(q_rel) : $signed(q_rel)) :
                             32'sh0000_0000;
    wire signed [31:0] back_d = back_q + sd - rel;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ms_cnt_q <= '0;
            div_st_q <= CPP_DIV_IDLE;
            dvd_q <= 32'h0000_0000;
            rem_q <= 33'h0_0000_0000;
            div_cnt_q <= 6'h00;
            div_neg_q <= 1'b0;
            div_done_q <= 1'b0;
        end else begin
            ms_cnt_q <= ms_tick ? '0 : ms_cnt_q + 1'b1;
            div_done_q <= 1'b0;
            case (div_st_q)
                CPP_DIV_IDLE: begin
                    if (div_start) begin
                        dvd_q <= back_mag;
                        div_neg_q <= back_q[31];
                        rem_q <= 33'h0_0000_0000;
                        div_cnt_q <= 6'h00;
                        div_st_q <= CPP_DIV_RUN;
                    end
                end
                CPP_DIV_RUN: begin
                    rem_q <= rem_ge ? rem_sh - 33'(smooth_q) : rem_sh;
                    dvd_q <= {dvd_q[30:0], rem_ge};
                    div_cnt_q <= div_cnt_q + 6'h01;
                    if (div_cnt_q == 6'h1F) begin
                        div_done_q <= ~smooth_off;
                        div_st_q <= CPP_DIV_IDLE;
                    end
                end
                default: begin
                    div_st_q <= CPP_DIV_IDLE;
                end
            endcase
        end
    end

    // Deviation counter
    wire signed [31:0] fb_step = fb_up ? 32'sh0000_0001 :
                                 fb_dn ? -32'sh0000_0001 : 32'sh0000_0000;
    wire signed [31:0] droop_d = clr_rise ? 32'sh0000_0000 : droop_q + rel - fb_step;
    wire [31:0] droop_mag = droop_q[31] ? 32'(-droop_q) : 32'(droop_q);
    wire inpos_d = (droop_mag < 32'(inpos_q));

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            frac_q <= 36'sh0_0000_0000;
            back_q <= 32'sh0000_0000;
            droop_q <= 32'sh0000_0000;
            inposition_flag_o <= 1'b0;
            speed_cmd_o <= 41'sh000_0000_0000;
        end else begin
            frac_q <= frac_d;
            back_q <= back_d;
            droop_q <= droop_d;
            inposition_flag_o <= inpos_d;
            // Speed demand is droop times gain, so steady droop is rate over gain
            speed_cmd_o <= 41'(droop_q * $signed({1'b0, gain_q}));
        end
    end

    // Wishbone slave, one wait state, unmapped reads return zero
    wire wb_hit = wb_req_i.cyc & wb_req_i.stb & ~wb_rsp_o.ack;
    wire wb_wr = wb_hit & wb_req_i.we;
    wire [7:0] wadr = {wb_req_i.adr[7:2], 2'b00};
    wire [31:0] wdat = wb_req_i.dat;
    wire [3:0] wsel = wb_req_i.sel;
    wire [31:0] gear_rd = {1'b0, gear_den_q, 1'b0, gear_num_q};
    wire [31:0] ctrl_m = cpp_merge({29'h0, form_q}, wdat, wsel);
    wire [31:0] gear_m = cpp_merge(gear_rd, wdat, wsel);
    wire [31:0] gain_m = cpp_merge({24'h00_0000, gain_q}, wdat, wsel);
    wire [31:0] smooth_m = cpp_merge({16'h0000, smooth_q}, wdat, wsel);
    wire [31:0] inpos_m = cpp_merge({17'h0_0000, inpos_q}, wdat, wsel);
    wire [31:0] en_m = cpp_merge({29'h0, int_en_q}, wdat, wsel);
    wire [31:0] clr_m = cpp_merge(32'h0000_0000, wdat, wsel);
    wire [2:0] int_clr = (wb_wr & (wadr == `CPP_ADR_INT_CLR)) ? clr_m[2:0] : 3'h0;
    wire [31:0] rd_mux =
        (wadr == `CPP_ADR_CTRL) ? {29'h0, form_q} :
        (wadr == `CPP_ADR_GEAR) ? gear_rd :
        (wadr == `CPP_ADR_GAIN) ? {24'h00_0000, gain_q} :
        (wadr == `CPP_ADR_SMOOTH) ? {16'h0000, smooth_q} :
        (wadr == `CPP_ADR_INPOS) ? {17'h0_0000, inpos_q} :
        (wadr == `CPP_ADR_DROOP) ? droop_q :
        (wadr == `CPP_ADR_STATUS) ? {29'h0, status_q} :
        (wadr == `CPP_ADR_INT_EN) ? {29'h0, int_en_q} : 32'h0000_0000;

    // Events; a new event in the clearing cycle stays set
    logic [2:0] ev;
    always_comb begin
        ev = 3'h0;
        ev[`CPP_IRQ_INPOS] = inpos_d & ~inposition_flag_o;
        ev[`CPP_IRQ_CLEAR] = clr_rise;
        ev[`CPP_IRQ_QERR] = quad_err;
    end
    wire [2:0] status_d = (status_q & ~int_clr) | ev;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_rsp_o <= '0;
            form_q <= `CPP_RST_FORM;
            gear_num_q <= `CPP_RST_GEAR_NUM;
            gear_den_q <= `CPP_RST_GEAR_DEN;
            gain_q <= `CPP_RST_GAIN;
            smooth_q <= `CPP_RST_SMOOTH;
            inpos_q <= `CPP_RST_INPOS;
            status_q <= 3'h0;
            int_en_q <= 3'h0;
            irq_o <= 1'b0;
        end else begin
            wb_rsp_o.ack <= wb_hit;
            wb_rsp_o.dat <= wb_hit ? rd_mux : 32'h0000_0000;
            status_q <= status_d;
            irq_o <= |(status_d & int_en_q);
            if (wb_wr) begin
                case (wadr)
                    `CPP_ADR_CTRL: form_q <= ctrl_m[2:0];
                    `CPP_ADR_GEAR: begin
                        gear_num_q <= gear_m[`CPP_GEAR_NUM_LSB +: 15];
                        gear_den_q <= gear_m[`CPP_GEAR_DEN_LSB +: 15];
                    end
                    `CPP_ADR_GAIN: gain_q <= gain_m[7:0];
                    `CPP_ADR_SMOOTH: smooth_q <= smooth_m[15:0];
                    `CPP_ADR_INPOS: inpos_q <= inpos_m[14:0];
                    `CPP_ADR_INT_EN: int_en_q <= en_m[2:0];
                    default: begin
                    end
                endcase
            end
        end
    end
endmodule : cpp_position_input
`default_nettype wire

// ---- verilog/cpp_params.svh ----
// Offsets, field positions, reset values and timing counts of the command pulse front end
`ifndef CPP_PARAMS_SVH
`define CPP_PARAMS_SVH
`define CPP_ADR_CTRL 8'h00
`define CPP_ADR_GEAR 8'h04
`define CPP_ADR_GAIN 8'h08
`define CPP_ADR_SMOOTH 8'h0C
`define CPP_ADR_INPOS 8'h10
`define CPP_ADR_DROOP 8'h14
`define CPP_ADR_STATUS 8'h18
`define CPP_ADR_INT_EN 8'h1C
`define CPP_ADR_INT_CLR 8'h20
`define CPP_GEAR_NUM_LSB 0
`define CPP_GEAR_DEN_LSB 16
`define CPP_RST_FORM 3'h0
`define CPP_RST_GEAR_NUM 15'h0001
`define CPP_RST_GEAR_DEN 15'h0001
`define CPP_RST_GAIN 8'h19
`define CPP_RST_SMOOTH 16'h0000
`define CPP_RST_INPOS 15'h0064
`define CPP_IRQ_INPOS 0
`define CPP_IRQ_CLEAR 1
`define CPP_IRQ_QERR 2
`define CPP_CLK_PERIOD_NS 10
`define CPP_SMOOTH_RES_NS 1000000
`define CPP_MS_CYCLES (`CPP_SMOOTH_RES_NS / `CPP_CLK_PERIOD_NS)
`endif

// ---- verilog/cpp_pkg.sv ----
// Types shared by the command pulse front end
package cpp_pkg;
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } cpp_wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } cpp_wb_rsp_t;

    typedef enum logic [2:0] {
        CPP_FORM_SEP_NEG = 3'b000,
        CPP_FORM_STEP_NEG = 3'b001,
        CPP_FORM_QUAD_NEG = 3'b010,
        CPP_FORM_SEP_POS = 3'b011,
        CPP_FORM_STEP_POS = 3'b100,
        CPP_FORM_QUAD_POS = 3'b101
    } cpp_form_t;

    typedef enum logic {
        CPP_DIV_IDLE = 1'b0,
        CPP_DIV_RUN = 1'b1
    } cpp_div_state_t;

    function automatic logic [31:0] cpp_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r;
    endfunction : cpp_merge

    // Returns {count, forward, invalid} for one sample step of two phases
    function automatic logic [2:0] cpp_quad(input logic ap, input logic bp,
                                            input logic a, input logic b);
        logic ca;
        logic cb;
        ca = a ^ ap;
        cb = b ^ bp;
        return {ca ^ cb, a ^ bp, ca & cb};
    endfunction : cpp_quad
endpackage : cpp_pkg

// ---- test/cpp_position_input_props.sv ----
// Port-level assertions for the command pulse front end
`timescale 1ns/1ps
`default_nettype none
`include "cpp_params.svh"
module cpp_position_input_props
    import cpp_pkg::*;
#(
    parameter int MS_CYCLES = 100000
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire cpp_wb_req_t wb_req_i,
    input wire cpp_wb_rsp_t wb_rsp_o,
    input wire logic counter_clear_input_i,
    input wire logic inposition_flag_o,
    input wire logic irq_o,
    input wire logic signed [40:0] speed_cmd_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire logic req = wb_req_i.cyc && wb_req_i.stb;
    wire logic en_off = req && wb_req_i.we && wb_req_i.adr == `CPP_ADR_INT_EN
        && wb_req_i.sel[0] && wb_req_i.dat[2:0] == 3'h0;
    a_ack_one_shot: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
        else $error("ack held over two cycles");
    a_ack_follows_req: assert property (req && !wb_rsp_o.ack |=> wb_rsp_o.ack)
        else $error("request not acknowledged next cycle");
    a_no_stray_ack: assert property (!req |=> !wb_rsp_o.ack)
        else $error("ack without request");
    a_rdat_quiet: assert property (!wb_rsp_o.ack |-> wb_rsp_o.dat == 32'h0000_0000)
        else $error("read data outside ack");
    a_reset_outputs: assert property ($fell(rst_i) |-> !wb_rsp_o.ack && !irq_o
        && !inposition_flag_o) else $error("outputs active after reset");
    a_pins_settle: assert property ($fell(rst_i) |-> speed_cmd_o == 41'sh0 [*3])
        else $error("speed moved while pin history fills");
    a_irq_masked: assert property (en_off && wb_rsp_o.ack |=> !irq_o [*2])
        else $error("interrupt high with all enables off");
    a_clear_zeroes: assert property ($rose(counter_clear_input_i) |->
        ##[3:10] speed_cmd_o == 41'sh0) else $error("clear edge left droop");
    c_write: cover property (req && wb_req_i.we && wb_rsp_o.ack);
    c_irq: cover property ($rose(irq_o));
    c_inpos: cover property ($rose(inposition_flag_o));
endmodule : cpp_position_input_props
bind cpp_position_input cpp_position_input_props #(.MS_CYCLES(MS_CYCLES)) i_props (
    .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o),
    .counter_clear_input_i(counter_clear_input_i), .inposition_flag_o(inposition_flag_o),
    .irq_o(irq_o), .speed_cmd_o(speed_cmd_o));
`default_nettype wire

// ---- test/cpp_ctrl_model.sv ----
// Behavioural positioning controller emitting one command in a chosen form
`timescale 1ns/1ps
`default_nettype none
module cpp_ctrl_model
    import cpp_pkg::*;
#(
    parameter int GAP = 500
) (
    input wire logic clk_i,
    input wire cpp_form_t form_i,
    input wire logic dir_i,
    input wire logic go_i,
    output var logic fwd_o,
    output var logic rev_o,
    output var logic done_o
);
    // GAP cycles per edge keeps even x4 quadrature at 200 kpps, at the cost of run time
    logic pos;
    logic [7:0] seq;
    task automatic put(input logic [1:0] lv);
        fwd_o <= lv[1] ^ ~pos;
        rev_o <= lv[0] ^ ~pos;
        repeat (GAP) @(posedge clk_i);
    endtask : put
    initial begin
        fwd_o = 1'b1;
        rev_o = 1'b1;
        done_o = 1'b0;
    end
    always begin
        @(posedge clk_i);
        if (go_i) begin
            pos = form_i >= CPP_FORM_SEP_POS;
            // Forms above 5 replay both phases flipping at once, an illegal pattern
            seq = (form_i > CPP_FORM_QUAD_POS) ? 8'hCC : dir_i ? 8'hB4 : 8'h78;
            put(2'h0);
            case (form_i)
                CPP_FORM_SEP_NEG, CPP_FORM_SEP_POS: put({dir_i, ~dir_i});
                CPP_FORM_STEP_NEG, CPP_FORM_STEP_POS: begin
                    put({1'b0, dir_i});
                    put({1'b1, dir_i});
                    put({1'b0, dir_i});
                end
                default: for (int i = 3; i >= 0; i--) put(seq[2*i +: 2]);
            endcase
            put(2'h0);
            done_o <= 1'b1;
            @(posedge clk_i);
            done_o <= 1'b0;
        end
    end
endmodule : cpp_ctrl_model
`default_nettype wire

// ---- test/test_command_pulse_position_input.sv ----
// Self-checking bench for the command pulse front end
`timescale 1ns/1ps
`default_nettype none
`include "cpp_params.svh"
module test_command_pulse_position_input import cpp_pkg::*;;
    // Row: form, forward flag, expected droop step
    typedef struct packed {
        logic [2:0] form;
        logic dir;
        logic signed [3:0] delta;
    } cpp_row_t;
    cpp_row_t rows [12] = '{8'h11, 8'h0F, 8'h31, 8'h2F, 8'h54, 8'h4C,
        8'h71, 8'h6F, 8'h91, 8'h8F, 8'hB4, 8'hAC};
    // Status reads 1 after reset: the in-position flag rises as soon as reset ends
    logic [39:0] rst_vals [9] = '{40'h00_0000_0000, 40'h04_0001_0001, 40'h08_0000_0019,
        40'h0C_0000_0000, 40'h10_0000_0064, 40'h14_0000_0000, 40'h18_0000_0001,
        40'h1C_0000_0000, 40'h24_0000_0000};
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    cpp_wb_req_t wb_req = '0;
    cpp_wb_rsp_t wb_rsp;
    cpp_form_t form_sel = CPP_FORM_SEP_NEG;
    logic fwd, rev, inpos, irq, done;
    logic clr = 1'b0;
    logic enc_a = 1'b0;
    logic enc_b = 1'b0;
    logic dir = 1'b0;
    logic go = 1'b0;
    logic signed [40:0] speed;
    logic [31:0] rd;
    int fail_count = 0;
    int checked = 0;
    int exp = 0;
    int n;
    always #5 clk_i = ~clk_i;
    cpp_position_input #(.MS_CYCLES(50)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_rsp_o(wb_rsp),
        .fwd_pulse_input_i(fwd), .rev_pulse_input_i(rev), .counter_clear_input_i(clr),
        .enc_a_i(enc_a), .enc_b_i(enc_b), .inposition_flag_o(inpos), .irq_o(irq),
        .speed_cmd_o(speed));
    cpp_ctrl_model #(.GAP(500)) i_ctrl (.clk_i(clk_i), .form_i(form_sel), .dir_i(dir),
        .go_i(go), .fwd_o(fwd), .rev_o(rev), .done_o(done));
    task automatic check(input logic [40:0] seen, input logic [40:0] want);
        checked++;
        if (seen !== want) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, want);
        end
    endtask : check
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
        n = 0;
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: wd};
        @(posedge clk_i);
        while (wb_rsp.ack !== 1'b1 && n < 50) begin
            @(posedge clk_i);
            n++;
        end
        if (n == 50) fail_count++;
        rd = wb_rsp.dat;
        wb_req <= '0;
        @(posedge clk_i);
    endtask : wb
    task automatic fire(input logic [2:0] f, input logic d);
        form_sel <= cpp_form_t'(f);
        dir <= d;
        go <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 4000) begin
            @(posedge clk_i);
            n++;
        end
        if (n == 4000) fail_count++;
        @(posedge clk_i);
    endtask : fire
    // Droop reads back signed; speed is droop times the default gain
    task automatic droop_is(input int want);
        wb(1'b0, `CPP_ADR_DROOP, 32'h0000_0000);
        check({{9{rd[31]}}, rd}, 41'(want));
        check(speed, 41'(want * 25));
    endtask : droop_is
    task automatic enc_cycle(input logic [7:0] s);
        for (int i = 3; i >= 0; i--) begin
            {enc_a, enc_b} <= s[2*i +: 2];
            repeat (4) @(posedge clk_i);
        end
    endtask : enc_cycle
    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        foreach (rst_vals[i]) begin
            wb(1'b0, rst_vals[i][39:32], 32'h0000_0000);
            check(41'(rd), 41'(rst_vals[i][31:0]));
        end
        check(41'(inpos), 41'h1);
        foreach (rows[i]) begin
            wb(1'b1, `CPP_ADR_CTRL, {29'h0, rows[i].form});
            fire(rows[i].form, rows[i].dir);
            exp += rows[i].delta;
            droop_is(exp);
        end
        wb(1'b1, `CPP_ADR_CTRL, 32'h0000_0003);
        wb(1'b1, `CPP_ADR_GEAR, 32'h0002_0003);
        fire(3'h3, 1'b1);
        fire(3'h3, 1'b1);
        exp += 3;
        droop_is(exp);
        wb(1'b1, `CPP_ADR_GEAR, 32'h0000_0003);
        fire(3'h3, 1'b1);
        droop_is(exp);
        enc_cycle(8'hB4);
        exp -= 4;
        droop_is(exp);
        wb(1'b1, `CPP_ADR_INPOS, 32'h0000_0001);
        repeat (3) @(posedge clk_i);
        check(41'(inpos), 41'h0);
        wb(1'b1, `CPP_ADR_INT_EN, 32'h0000_0007);
        clr <= 1'b1;
        repeat (10) @(posedge clk_i);
        droop_is(0);
        check(41'(inpos), 41'h1);
        check(41'(irq), 41'h1);
        wb(1'b0, `CPP_ADR_STATUS, 32'h0000_0000);
        check(41'(rd), 41'h3);
        wb(1'b1, `CPP_ADR_INT_CLR, 32'h0000_0007);
        repeat (2) @(posedge clk_i);
        check(41'(irq), 41'h0);
        wb(1'b1, `CPP_ADR_INT_EN, 32'h0000_0000);
        clr <= 1'b0;
        repeat (6) @(posedge clk_i);
        clr <= 1'b1;
        repeat (10) @(posedge clk_i);
        check(41'(irq), 41'h0);
        wb(1'b0, `CPP_ADR_STATUS, 32'h0000_0000);
        check(41'(rd), 41'h2);
        wb(1'b1, `CPP_ADR_GEAR, 32'h0001_0028);
        // Both phases flip together: nothing may count even at a gear of 40
        wb(1'b1, `CPP_ADR_CTRL, 32'h0000_0005);
        fire(3'h6, 1'b1);
        droop_is(0);
        wb(1'b0, `CPP_ADR_STATUS, 32'h0000_0000);
        check(41'(rd), 41'h6);
        wb(1'b1, `CPP_ADR_CTRL, 32'h0000_0003);
        wb(1'b1, `CPP_ADR_SMOOTH, 32'h0000_0032);
        fire(3'h3, 1'b1);
        wb(1'b0, `CPP_ADR_DROOP, 32'h0000_0000);
        check(41'(rd > 0 && rd < 40), 41'h1);
        repeat (2000) @(posedge clk_i);
        droop_is(40);
        final_report();
    end
    initial begin
        repeat (80000) @(posedge clk_i);
        fail_count++;
        final_report();
    end
endmodule : test_command_pulse_position_input
`default_nettype wire
